// >>> design/rmpc_pkg.sv
// Package for the redriver mode and power control block.
// Assumes a 100 MHz system clock and synchronous, already-sampled strap levels.
`default_nettype none
package rmpc_pkg;
	// Four-level strap levels
	typedef enum logic [1:0] {
		LVL_ZERO = 2'h0,
		LVL_R = 2'h1,
		LVL_F = 2'h2,
		LVL_ONE = 2'h3
	} rmpc_level_t;
	// Power states, one-hot
	typedef enum logic [2:0] {
		ST_POWER_DOWN = 3'h1,
		ST_STANDBY = 3'h2,
		ST_NORMAL = 3'h4
	} rmpc_state_t;
	// Register-mode control bits from the serial register file
	typedef struct packed {
		logic power_down_request;
		logic standby_inhibit;
		logic hot_plug_power_down_inhibit;
		logic snoop_enable;
		logic lane_swap;
		logic linear_mode;
		logic alt_link_mode;
	} rmpc_regs_t;
	// Decoded configuration seen by the analog side
	typedef struct packed {
		logic register_mode;
		logic buffer_enable;
		logic snoop_enable;
		logic lane_swap;
		logic alt_link_mode;
		logic term_300_always;
		logic term_open_low_rate;
		logic linear_mode;
		logic [1:0] equalizer;
		logic [1:0] swing;
		logic [1:0] emphasis;
	} rmpc_cfg_t;
	// Lane power controls
	typedef struct packed {
		logic clock_receiver_on;
		logic all_receivers_on;
		logic transmitters_on;
		logic channel_on;
	} rmpc_power_t;
	localparam int CLK_PERIOD_NS = 10;
	localparam int PD_DELAY_US = 100;
	localparam int STBY_QUAL_US = 100;
	localparam int DEBOUNCE_US = 10;
	localparam int STBY_ENTRY_US = 10;
	localparam int PD_DELAY_CYC = PD_DELAY_US * 1000 / CLK_PERIOD_NS;
	localparam int STBY_QUAL_CYC = STBY_QUAL_US * 1000 / CLK_PERIOD_NS;
	localparam int DEBOUNCE_CYC = (DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STBY_ENTRY_CYC = STBY_ENTRY_US * 1000 / CLK_PERIOD_NS;
	localparam logic [6:0] SNOOP_TARGET = 7'h54;
	localparam logic [7:0] SNOOP_OFFSET = 8'h20;
	localparam int RATIO_BIT = 1;
	localparam logic [6:0] ADDR_BASE_0 = 7'h5e;
	localparam logic [6:0] ADDR_BASE_R = 7'h5d;
	localparam logic [6:0] ADDR_BASE_F = 7'h5c;
	localparam logic [6:0] ADDR_BASE_1 = 7'h5b;
endpackage : rmpc_pkg
`default_nettype wire

// >>> design/rmpc_top.sv
// Mode decode, channel snoop and power state control of a video-link redriver.
// Assumes strap and line inputs are synchronous to clk_sys_in.
`default_nettype none
module rmpc_top (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic enable_in,
	input wire logic hot_plug_input_in,
	input wire logic clock_idle_in,
	input wire rmpc_pkg::rmpc_level_t mode_pin_in,
	input wire rmpc_pkg::rmpc_level_t address_equalizer_strap_in,
	input wire logic [1:0] equalizer_straps_in,
	input wire logic clock_configuration_strap_in,
	input wire logic data_configuration_strap_in,
	input wire logic coupling_select_pin_in,
	input wire logic hot_plug_output_select_in,
	input wire logic [1:0] swing_strap_in,
	input wire logic [1:0] emphasis_strap_in,
	input wire logic linear_strap_in,
	input wire rmpc_pkg::rmpc_regs_t regs_in,
	input wire logic low_side_channel_clock_in,
	input wire logic low_side_channel_data_in,
	output logic [6:0] target_address_out,
	output logic serial_lines_enable_out,
	output rmpc_pkg::rmpc_cfg_t cfg_out,
	output rmpc_pkg::rmpc_power_t power_out,
	output rmpc_pkg::rmpc_state_t state_out,
	output logic power_down_request_out,
	output logic clock_ratio_bit_out,
	output logic hot_plug_output_out,
	output logic hot_plug_output_oe_out
);
	rmpc_pkg::rmpc_state_t state_reg, state_next;
	logic sampled_reg;
	logic reg_mode_reg, buffer_en_reg, coupling_reg, out_sel_reg, data_strap_reg;
	logic [1:0] eq_reg, swing_reg, emph_reg;
	logic linear_reg;
	logic [6:0] addr_reg;
	logic clk_strap_reg;
	logic [31:0] hp_low_cnt_reg, hp_high_cnt_reg;
	logic [15:0] det_cnt_reg, idle_cnt_reg;
	logic ratio_reg;
	logic pd_req;
	logic alt_mode;
	logic snoop_on;
	logic hp_eff;
	logic signal_valid;
	logic idle_qual;

	function automatic logic [6:0] addr_of(input rmpc_pkg::rmpc_level_t lvl);
		case (lvl)
			rmpc_pkg::LVL_ZERO: addr_of = rmpc_pkg::ADDR_BASE_0;
			rmpc_pkg::LVL_R: addr_of = rmpc_pkg::ADDR_BASE_R;
			rmpc_pkg::LVL_F: addr_of = rmpc_pkg::ADDR_BASE_F;
			default: addr_of = rmpc_pkg::ADDR_BASE_1;
		endcase
	endfunction : addr_of

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sampled_reg <= 1'b0;
			reg_mode_reg <= 1'b0;
			buffer_en_reg <= 1'b0;
			coupling_reg <= 1'b0;
			out_sel_reg <= 1'b0;
			data_strap_reg <= 1'b0;
			eq_reg <= 2'h0;
			swing_reg <= 2'h0;
			emph_reg <= 2'h0;
			linear_reg <= 1'b0;
			addr_reg <= 7'h00;
		end else if (!sampled_reg) begin
			sampled_reg <= 1'b1;
			reg_mode_reg <= (mode_pin_in == rmpc_pkg::LVL_F);
			buffer_en_reg <= (mode_pin_in == rmpc_pkg::LVL_ZERO);
			coupling_reg <= coupling_select_pin_in;
			out_sel_reg <= hot_plug_output_select_in;
			data_strap_reg <= data_configuration_strap_in;
			eq_reg <= equalizer_straps_in;
			swing_reg <= swing_strap_in;
			emph_reg <= emphasis_strap_in;
			linear_reg <= linear_strap_in;
			addr_reg <= addr_of(address_equalizer_strap_in);
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			clk_strap_reg <= 1'b0;
		end else begin
			clk_strap_reg <= clock_configuration_strap_in;
		end
	end

	// Register mode powers up requested down
	assign pd_req = !sampled_reg || (reg_mode_reg && regs_in.power_down_request);
	assign alt_mode = reg_mode_reg ? regs_in.alt_link_mode : (coupling_reg && clk_strap_reg);
	assign snoop_on = reg_mode_reg ? regs_in.snoop_enable : !alt_mode;
	assign hp_eff = hot_plug_input_in || (reg_mode_reg && regs_in.hot_plug_power_down_inhibit);

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			hp_low_cnt_reg <= 32'h0;
			hp_high_cnt_reg <= 32'h0;
		end else begin
			hp_low_cnt_reg <= hp_eff ? 32'h0 :
				(hp_low_cnt_reg < 32'(rmpc_pkg::PD_DELAY_CYC) ? hp_low_cnt_reg + 32'h1 : hp_low_cnt_reg);
			hp_high_cnt_reg <= !hp_eff ? 32'h0 :
				(hp_high_cnt_reg < 32'(rmpc_pkg::STBY_QUAL_CYC) ? hp_high_cnt_reg + 32'h1 : hp_high_cnt_reg);
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			det_cnt_reg <= 16'h0;
			idle_cnt_reg <= 16'h0;
		end else begin
			det_cnt_reg <= clock_idle_in ? 16'h0 :
				(det_cnt_reg < 16'(rmpc_pkg::DEBOUNCE_CYC) ? det_cnt_reg + 16'h1 : det_cnt_reg);
			idle_cnt_reg <= !clock_idle_in ? 16'h0 :
				(idle_cnt_reg < 16'(rmpc_pkg::STBY_ENTRY_CYC) ? idle_cnt_reg + 16'h1 : idle_cnt_reg);
		end
	end
	assign signal_valid = (det_cnt_reg >= 16'(rmpc_pkg::DEBOUNCE_CYC));
	assign idle_qual = clock_idle_in && (idle_cnt_reg < 16'(rmpc_pkg::STBY_ENTRY_CYC));

	// Power state transitions
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			rmpc_pkg::ST_POWER_DOWN: begin
				if (enable_in && !pd_req && hp_high_cnt_reg >= 32'(rmpc_pkg::STBY_QUAL_CYC)) begin
					state_next = rmpc_pkg::ST_STANDBY;
				end
			end
			rmpc_pkg::ST_STANDBY: begin
				if (signal_valid || (reg_mode_reg && regs_in.standby_inhibit) || alt_mode) begin
					state_next = rmpc_pkg::ST_NORMAL;
				end
			end
			rmpc_pkg::ST_NORMAL: begin
				if (clock_idle_in && !(reg_mode_reg && regs_in.standby_inhibit) && !alt_mode) begin
					state_next = rmpc_pkg::ST_STANDBY;
				end
			end
			default: state_next = rmpc_pkg::ST_POWER_DOWN;
		endcase
		if (!enable_in || pd_req || hp_low_cnt_reg >= 32'(rmpc_pkg::PD_DELAY_CYC)) begin
			state_next = rmpc_pkg::ST_POWER_DOWN;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= rmpc_pkg::ST_POWER_DOWN;
		end else begin
			state_reg <= state_next;
		end
	end

	logic scl_d_reg, sda_d_reg, active_reg, match_reg, rw_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [1:0] byte_idx_reg;
	logic [7:0] offs_reg;
	logic ack_slot;
	wire start_cond = scl_d_reg && low_side_channel_clock_in && sda_d_reg && !low_side_channel_data_in;
	wire stop_cond = scl_d_reg && low_side_channel_clock_in && !sda_d_reg && low_side_channel_data_in;
	wire scl_rise = !scl_d_reg && low_side_channel_clock_in;
	assign ack_slot = (bit_cnt_reg == 4'h8);
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			active_reg <= 1'b0;
			match_reg <= 1'b0;
			rw_reg <= 1'b0;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			byte_idx_reg <= 2'h0;
			offs_reg <= 8'h00;
		end else begin
			scl_d_reg <= low_side_channel_clock_in;
			sda_d_reg <= low_side_channel_data_in;
			if (start_cond) begin
				active_reg <= 1'b1;
				bit_cnt_reg <= 4'h0;
				byte_idx_reg <= 2'h0;
			end else if (stop_cond) begin
				active_reg <= 1'b0;
			end else if (active_reg && scl_rise) begin
				if (ack_slot) begin
					bit_cnt_reg <= 4'h0;
					if (byte_idx_reg != 2'h3) begin
						byte_idx_reg <= byte_idx_reg + 2'h1;
					end
					if (byte_idx_reg == 2'h0) begin
						match_reg <= (shift_reg[7:1] == rmpc_pkg::SNOOP_TARGET);
						rw_reg <= shift_reg[0];
					end else if (byte_idx_reg == 2'h1 && !rw_reg) begin
						offs_reg <= shift_reg;
					end
				end else begin
					shift_reg <= {shift_reg[6:0], low_side_channel_data_in};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
			end
		end
	end

	// Rate reverts on power-down, kept in standby
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ratio_reg <= 1'b0;
		end else if (state_reg == rmpc_pkg::ST_POWER_DOWN) begin
			ratio_reg <= 1'b0;
		end else if (snoop_on && active_reg && scl_rise && ack_slot && match_reg
			&& byte_idx_reg == (rw_reg ? 2'h1 : 2'h2) && offs_reg == rmpc_pkg::SNOOP_OFFSET) begin
			ratio_reg <= shift_reg[rmpc_pkg::RATIO_BIT];
		end
	end

	assign state_out = state_reg;
	assign power_down_request_out = pd_req;
	assign clock_ratio_bit_out = ratio_reg;
	assign target_address_out = addr_reg;
	assign serial_lines_enable_out = enable_in && reg_mode_reg;

	always_comb begin
		power_out.clock_receiver_on = (state_reg != rmpc_pkg::ST_POWER_DOWN);
		power_out.all_receivers_on = (state_reg == rmpc_pkg::ST_NORMAL);
		power_out.transmitters_on = (state_reg == rmpc_pkg::ST_NORMAL);
		power_out.channel_on = (state_reg != rmpc_pkg::ST_POWER_DOWN) && buffer_en_reg;
	end

	always_comb begin
		cfg_out.register_mode = reg_mode_reg;
		cfg_out.buffer_enable = buffer_en_reg;
		cfg_out.snoop_enable = snoop_on;
		cfg_out.alt_link_mode = alt_mode;
		cfg_out.lane_swap = reg_mode_reg ? regs_in.lane_swap : data_strap_reg;
		cfg_out.term_300_always = !reg_mode_reg && !coupling_reg && clk_strap_reg;
		cfg_out.term_open_low_rate = !reg_mode_reg && !coupling_reg && !clk_strap_reg;
		cfg_out.linear_mode = reg_mode_reg ? regs_in.linear_mode : linear_reg;
		cfg_out.equalizer = reg_mode_reg ? 2'h0 : eq_reg;
		cfg_out.swing = (reg_mode_reg || cfg_out.linear_mode) ? 2'h0 : swing_reg;
		cfg_out.emphasis = (reg_mode_reg || cfg_out.linear_mode) ? 2'h0 : emph_reg;
	end

	// Hot-plug output low while power-down requested
	always_comb begin
		hot_plug_output_oe_out = enable_in;
		if (pd_req || state_reg == rmpc_pkg::ST_POWER_DOWN) begin
			hot_plug_output_out = 1'b0;
		end else begin
			hot_plug_output_out = hp_eff;
		end
	end

	property p_hpd_low;
		@(posedge clk_sys_in) disable iff (rst_in) pd_req |-> !hot_plug_output_out;
	endproperty
	a_hpd_low: assert property (p_hpd_low) else $error("hot-plug high while down requested");
	property p_pd_entry;
		@(posedge clk_sys_in) disable iff (rst_in) !enable_in |=> state_reg == rmpc_pkg::ST_POWER_DOWN;
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("no power-down when disabled");
	property p_rate_reset;
		@(posedge clk_sys_in) disable iff (rst_in)
			state_reg == rmpc_pkg::ST_POWER_DOWN |=> !ratio_reg;
	endproperty
	a_rate_reset: assert property (p_rate_reset) else $error("rate kept in power-down");
	property p_normal_tx;
		@(posedge clk_sys_in) disable iff (rst_in)
			power_out.transmitters_on |-> state_reg == rmpc_pkg::ST_NORMAL;
	endproperty
	a_normal_tx: assert property (p_normal_tx) else $error("transmit outside normal");
	property p_idle_back;
		@(posedge clk_sys_in) disable iff (rst_in)
			state_reg == rmpc_pkg::ST_NORMAL && clock_idle_in && !alt_mode && enable_in
			&& !(reg_mode_reg && regs_in.standby_inhibit) |=> state_reg != rmpc_pkg::ST_NORMAL;
	endproperty
	a_idle_back: assert property (p_idle_back) else $error("normal kept while idle");
	property p_released;
		@(posedge clk_sys_in) disable iff (rst_in) !enable_in |-> !hot_plug_output_oe_out && !serial_lines_enable_out;
	endproperty
	a_released: assert property (p_released) else $error("lines driven while disabled");
	property p_alt_snoop;
		@(posedge clk_sys_in) disable iff (rst_in) (!reg_mode_reg && alt_mode) |-> !snoop_on;
	endproperty
	a_alt_snoop: assert property (p_alt_snoop) else $error("snoop on in alternate mode");
	property p_qual;
		@(posedge clk_sys_in) disable iff (rst_in)
			$past(state_reg) == rmpc_pkg::ST_POWER_DOWN && state_reg == rmpc_pkg::ST_STANDBY
			|-> $past(hp_high_cnt_reg) >= 32'(rmpc_pkg::STBY_QUAL_CYC);
	endproperty
	a_qual: assert property (p_qual) else $error("standby without qualification");
	wire unused_ok = idle_qual ^ out_sel_reg;
endmodule : rmpc_top
`default_nettype wire

// >>> testbench/rmpc_channel_model.sv
// Far-side traffic model for the low-side display data channel lines.
// Assumes pulled-up lines that the block under test only samples.
`default_nettype none
module rmpc_channel_model (
	input wire logic clk_sys_in,
	output logic scl_out,
	output logic sda_out
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 20;
	// Released lines rest at the pull-up level
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic wait_half();
		repeat (HALF) @(negedge clk_sys_in);
	endtask : wait_half
	// Data changes only while the clock line is low
	task automatic send_bit(input logic b);
		sda_out = b;
		wait_half();
		scl_out = 1'b1;
		wait_half();
		scl_out = 1'b0;
	endtask : send_bit
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			send_bit(b[i]);
		end
		// Far end acknowledges
		send_bit(1'b0);
	endtask : send_byte
	task automatic send_start();
		sda_out = 1'b0;
		wait_half();
		scl_out = 1'b0;
	endtask : send_start
	task automatic send_stop();
		sda_out = 1'b0;
		wait_half();
		scl_out = 1'b1;
		wait_half();
		sda_out = 1'b1;
		wait_half();
	endtask : send_stop
	// Start, status target, offset, data, stop
	task automatic write_reg(input logic [7:0] offset, input logic [7:0] data);
		send_start();
		send_byte(8'ha8);
		send_byte(offset);
		send_byte(data);
		send_stop();
	endtask : write_reg
	// Read from the offset of the last write
	task automatic read_reg(input logic [7:0] data);
		send_start();
		send_byte(8'ha9);
		send_byte(data);
		send_stop();
	endtask : read_reg
endmodule : rmpc_channel_model
`default_nettype wire

// >>> testbench/test_rmpc_top.sv
// Self-checking bench for the redriver mode and power control block.
// Assumes the channel model drives the low-side lines with pull-ups.
`default_nettype none
module test_rmpc_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic enable = 1'b1;
	logic hot_plug = 1'b1;
	logic clock_idle = 1'b1;
	rmpc_pkg::rmpc_level_t mode_pin = rmpc_pkg::LVL_ZERO;
	rmpc_pkg::rmpc_level_t addr_strap = rmpc_pkg::LVL_ZERO;
	logic [1:0] eq_straps = 2'h2;
	logic clk_strap = 1'b0;
	logic data_strap = 1'b1;
	logic coupling = 1'b0;
	logic hp_select = 1'b0;
	logic [1:0] swing = 2'h1;
	logic [1:0] emphasis = 2'h3;
	logic linear = 1'b0;
	rmpc_pkg::rmpc_regs_t regs = '{power_down_request: 1'b1, snoop_enable: 1'b1, default: 1'b0};
	logic scl;
	logic sda;
	logic [6:0] target_address;
	logic serial_en;
	rmpc_pkg::rmpc_cfg_t cfg;
	rmpc_pkg::rmpc_power_t power;
	rmpc_pkg::rmpc_state_t state;
	logic pd_req;
	logic ratio;
	logic hp_out;
	logic hp_oe;
	int error_cnt = 0;
	int checked = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	rmpc_top i_rmpc_top (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .enable_in(enable),
		.hot_plug_input_in(hot_plug), .clock_idle_in(clock_idle), .mode_pin_in(mode_pin),
		.address_equalizer_strap_in(addr_strap), .equalizer_straps_in(eq_straps),
		.clock_configuration_strap_in(clk_strap), .data_configuration_strap_in(data_strap),
		.coupling_select_pin_in(coupling), .hot_plug_output_select_in(hp_select),
		.swing_strap_in(swing), .emphasis_strap_in(emphasis), .linear_strap_in(linear),
		.regs_in(regs), .low_side_channel_clock_in(scl), .low_side_channel_data_in(sda),
		.target_address_out(target_address), .serial_lines_enable_out(serial_en),
		.cfg_out(cfg), .power_out(power), .state_out(state), .power_down_request_out(pd_req),
		.clock_ratio_bit_out(ratio), .hot_plug_output_out(hp_out),
		.hot_plug_output_oe_out(hp_oe));
	rmpc_channel_model i_rmpc_channel_model (.clk_sys_in(clk_sys_in), .scl_out(scl),
		.sda_out(sda));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wait_state(input rmpc_pkg::rmpc_state_t exp, input int limit);
		int n;
		n = 0;
		while (state !== exp && n < limit) begin
			@(negedge clk_sys_in);
			n++;
		end
		check(16'(state), 16'(exp));
	endtask : wait_state
	task automatic do_reset();
		rst_in = 1'b1;
		repeat (8) @(negedge clk_sys_in);
		rst_in = 1'b0;
		repeat (3) @(negedge clk_sys_in);
	endtask : do_reset
	task automatic complete_run();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run
	// Watchdog well beyond the longest qualification wait
	initial begin
		#400000;
		error_cnt++;
		complete_run();
	end
	initial begin
		// Strap mode with buffer, coupling low
		do_reset();
		check(16'(state), 16'(rmpc_pkg::ST_POWER_DOWN)); // reset lands in power-down
		check(16'(ratio), 16'h0); // legacy rate after reset
		check(16'(cfg.lane_swap), 16'h1); // data strap swaps lanes
		check(16'(cfg.equalizer), 16'(eq_straps)); // equalizer from straps
		check(16'({cfg.swing, cfg.emphasis}), 16'h7); // limited levels from straps
		check(16'({cfg.register_mode, cfg.buffer_enable}), 16'h1); // mode 0 decode
		check(16'(cfg.snoop_enable), 16'h1); // snoop on in strap mode
		check(16'(cfg.term_300_always), 16'h0); // clock strap low
		data_strap = 1'b0;
		clk_strap = 1'b1;
		repeat (3) @(negedge clk_sys_in);
		check(16'(cfg.lane_swap), 16'h1); // data strap sampled once
		check(16'(cfg.term_300_always), 16'h1); // clock strap resampled
		wait_state(rmpc_pkg::ST_STANDBY, rmpc_pkg::STBY_QUAL_CYC + 20);
		check(16'(power), 16'h9); // clock receiver and channel in standby
		clock_idle = 1'b0;
		wait_state(rmpc_pkg::ST_NORMAL, rmpc_pkg::DEBOUNCE_CYC + 20);
		check(16'(power.all_receivers_on & power.transmitters_on), 16'h1); // lanes pass
		i_rmpc_channel_model.write_reg(8'h21, 8'h02);
		check(16'(ratio), 16'h0); // other offset ignored
		i_rmpc_channel_model.write_reg(8'h20, 8'h02);
		check(16'(ratio), 16'h1); // bit 1 set selects high rate
		i_rmpc_channel_model.write_reg(8'h20, 8'h00);
		check(16'(ratio), 16'h0); // bit 1 clear selects legacy rate
		i_rmpc_channel_model.read_reg(8'h02);
		check(16'(ratio), 16'h1); // snooped read sets high rate
		clock_idle = 1'b1;
		wait_state(rmpc_pkg::ST_STANDBY, rmpc_pkg::STBY_ENTRY_CYC + 5);
		check(16'(ratio), 16'h1); // rate kept across standby
		enable = 1'b0;
		wait_state(rmpc_pkg::ST_POWER_DOWN, 2); // enable low powers down
		@(negedge clk_sys_in);
		check(16'(ratio), 16'h0); // legacy rate on power-down
		check(16'({hp_oe, serial_en}), 16'h0); // lines released
		enable = 1'b1;
		// Register mode
		mode_pin = rmpc_pkg::LVL_F;
		addr_strap = rmpc_pkg::LVL_R;
		do_reset();
		check(16'(target_address), 16'(rmpc_pkg::ADDR_BASE_R)); // address from strap
		check(16'(serial_en), 16'h1); // serial lines active
		check(16'(pd_req), 16'h1); // powered down at start
		check(16'(hp_out), 16'h0); // output low while request set
		check(16'(cfg.register_mode), 16'h1); // mode F decode
		check(16'(cfg.lane_swap), 16'h0); // lane swap clear, register bit and data strap both low
		check(16'(cfg.snoop_enable), 16'h1); // snoop on by default
		// Program first, then clear the request
		regs.standby_inhibit = 1'b1;
		regs.hot_plug_power_down_inhibit = 1'b1;
		regs.lane_swap = 1'b1;
		regs.snoop_enable = 1'b0;
		@(negedge clk_sys_in);
		regs.power_down_request = 1'b0;
		hot_plug = 1'b0;
		repeat (3) @(negedge clk_sys_in);
		check(16'({cfg.lane_swap, cfg.snoop_enable}), 16'h2); // from registers
		wait_state(rmpc_pkg::ST_NORMAL, rmpc_pkg::STBY_QUAL_CYC + 20); // inhibit forces normal
		check(16'(hp_out), 16'h1); // inhibit drives output high
		// Strap mode, no buffer, coupling high
		mode_pin = rmpc_pkg::LVL_R;
		coupling = 1'b1;
		linear = 1'b1;
		do_reset();
		check(16'(cfg.buffer_enable), 16'h0); // mode R decode
		check(16'({cfg.linear_mode, cfg.swing, cfg.emphasis}), 16'h10); // linear
		check(16'({cfg.alt_link_mode, cfg.snoop_enable}), 16'h2); // alternate mode
		complete_run();
	end
endmodule : test_rmpc_top
`default_nettype wire
